// File: design/gpu_port.sv
// Functional notes
// RULE1: a first-port pin in general use is driven when its direction bit is 1, input when 0.
// RULE2: the first-port direction register is write-only and reads return an undefined value.
// RULE3: the first-port output data register holds eight read/write bits that feed output pins.
// RULE4: pin-state reads return output data for bits whose direction bit is 1.
// RULE5: pin-state reads return the sampled pin level for bits whose direction bit is 0.
// RULE6: the pin-state register is read-only and writes to it change nothing.
// RULE7: first-port bit n doubles as usb data bit n+8.
// RULE8: with the usb module-stop bit at 0 the usb data function owns the first-port pins.
// RULE9: the second port has eight pins, output when direction is 1, input when 0.
// RULE10: the second-port direction register is write-only and reads return an undefined value.
// RULE11: the second port has a read/write output data register feeding its output pins.
// RULE12: internal copies of the direction registers drive enables and read selection.
`timescale 1ns/1ns
`include "gpu_params.svh"
// =====================================================
// gpio port pair with usb upper data byte sharing
module gpu_port #(
    parameter int WIDTH = 8
) (
    input wire logic mclk, // system clock, 100 MHz
    input wire logic rstn, // async reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [WIDTH-1:0] port_a_in, // first-port pin levels
    output logic [WIDTH-1:0] port_a_out, // first-port pin drive value
    output logic [WIDTH-1:0] port_a_oe, // first-port pin enables
    input wire logic [WIDTH-1:0] port_b_in, // second-port pin levels
    output logic [WIDTH-1:0] port_b_out, // second-port pin drive value
    output logic [WIDTH-1:0] port_b_oe, // second-port pin enables
    input wire logic [15:8] usb_data_out, // usb data to pins
    input wire logic [15:8] usb_data_oe, // usb drive enables
    output logic [15:8] usb_data_in, // pin levels to usb
    output logic usb_module_stop_bit // module stop state
);
    import gpu_pkg::*;

    logic [WIDTH-1:0] port_a_direction;
    logic [WIDTH-1:0] port_a_output_data;
    logic [WIDTH-1:0] port_b_direction;
    logic [WIDTH-1:0] port_b_output_data;
    logic stop;
    logic [WIDTH-1:0] next_a_dir;
    logic [WIDTH-1:0] next_a_out;
    logic [WIDTH-1:0] next_b_dir;
    logic [WIDTH-1:0] next_b_out;
    logic next_stop;
    logic [WIDTH-1:0] a_sync;
    logic [WIDTH-1:0] b_sync;
    logic [WIDTH-1:0] port_a_pin_state;
    logic [WIDTH-1:0] port_b_pin_state;

    initial begin
        if (WIDTH != 8) begin
            $error("gpu_port: WIDTH must be 8 to match usb bits 15:8");
        end
    end

    // =====================================================
    // pin input synchronisers
    gpu_sync #(.WIDTH(WIDTH)) u_sync_a (
        .mclk(mclk),
        .rstn(rstn),
        .din(port_a_in),
        .dout(a_sync)
    );
    gpu_sync #(.WIDTH(WIDTH)) u_sync_b (
        .mclk(mclk),
        .rstn(rstn),
        .din(port_b_in),
        .dout(b_sync)
    );

    // internal direction copies select the read source
    assign port_a_pin_state = (port_a_direction & port_a_output_data)
        | (~port_a_direction & a_sync); // RULE4 RULE5 RULE12
    assign port_b_pin_state = (port_b_direction & port_b_output_data)
        | (~port_b_direction & b_sync);

    // =====================================================
    // write channel
    gpu_wstate_e wstate;
    gpu_wstate_e next_wstate;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_awready;
    logic next_wready;
    logic do_write;
    logic wr_hit;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_wstate = wstate;
        next_a_dir = port_a_direction;
        next_a_out = port_a_output_data;
        next_b_dir = port_b_direction;
        next_b_out = port_b_output_data;
        next_stop = stop;
        do_write = 1'b0;
        wr_hit = 1'b1;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        case (wstate)
            GPU_W_IDLE: begin
                if (aw_held && w_held) begin
                    do_write = 1'b1;
                    next_wstate = GPU_W_RESP;
                end
            end
            GPU_W_RESP: begin
                if (s_axi_bvalid && s_axi_bready) begin
                    next_bvalid = 1'b0;
                    next_wstate = GPU_W_IDLE;
                end
            end
            GPU_W_HOLD: begin
                next_wstate = GPU_W_IDLE;
            end
            default: begin
                next_wstate = GPU_W_IDLE;
            end
        endcase
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            if (w_strb[0]) begin
                case (aw_addr)
                    `GPU_OFS_A_DIR: next_a_dir = w_data[7:0]; // RULE1 RULE12
                    `GPU_OFS_A_OUT: next_a_out = w_data[7:0]; // RULE3
                    `GPU_OFS_A_PIN: wr_hit = 1'b1; // RULE6
                    `GPU_OFS_B_DIR: next_b_dir = w_data[7:0]; // RULE9
                    `GPU_OFS_B_OUT: next_b_out = w_data[7:0]; // RULE11
                    `GPU_OFS_B_PIN: wr_hit = 1'b1;
                    `GPU_OFS_CTRL: next_stop = w_data[`GPU_CTRL_STOP_BIT];
                    default: wr_hit = 1'b0;
                endcase
            end else begin
                wr_hit = (aw_addr <= `GPU_OFS_CTRL) && (aw_addr[1:0] == 2'h0);
            end
            next_bresp = wr_hit ? `GPU_RESP_OKAY : `GPU_RESP_SLVERR;
        end
        // accept a new address only while none is held, new data only while none is held, and either only in idle
        next_awready = !next_aw_held && (next_wstate == GPU_W_IDLE);
        next_wready = !next_w_held && (next_wstate == GPU_W_IDLE);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wstate <= GPU_W_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            port_a_direction <= `GPU_RST_DIR;
            port_a_output_data <= `GPU_RST_OUT;
            port_b_direction <= `GPU_RST_DIR;
            port_b_output_data <= `GPU_RST_OUT;
            stop <= `GPU_RST_CTRL;
        end else begin
            wstate <= next_wstate;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            port_a_direction <= next_a_dir;
            port_a_output_data <= next_a_out;
            port_b_direction <= next_b_dir;
            port_b_output_data <= next_b_out;
            stop <= next_stop;
        end
    end

    // =====================================================
    // read channel
    logic next_rvalid;
    logic next_arready;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_arready = s_axi_arready;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_arready = 1'b0;
            next_rresp = `GPU_RESP_OKAY;
            case (s_axi_araddr)
                `GPU_OFS_A_DIR: next_rdata = `GPU_UNDEF_VAL; // RULE2
                `GPU_OFS_A_OUT: next_rdata = {24'h000000, port_a_output_data};
                `GPU_OFS_A_PIN: next_rdata = {24'h000000, port_a_pin_state};
                `GPU_OFS_B_DIR: next_rdata = `GPU_UNDEF_VAL; // RULE10
                `GPU_OFS_B_OUT: next_rdata = {24'h000000, port_b_output_data};
                `GPU_OFS_B_PIN: next_rdata = {24'h000000, port_b_pin_state};
                `GPU_OFS_CTRL: next_rdata = {31'h0, stop};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = `GPU_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_arready <= next_arready;
        end
    end

    // =====================================================
    // pin multiplexing; registered so every pin output is a flop
    logic [WIDTH-1:0] next_pa_out;
    logic [WIDTH-1:0] next_pa_oe;
    logic [15:8] next_usb_in;

    always_comb begin
        if (!stop) begin
            next_pa_out = usb_data_out; // RULE7 RULE8
            next_pa_oe = usb_data_oe; // RULE8
        end else begin
            next_pa_out = port_a_output_data; // RULE3
            next_pa_oe = port_a_direction; // RULE1 RULE12
        end
        // usb sees the pins whatever the mode; it ignores them when stopped
        next_usb_in = a_sync; // RULE7
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            port_a_out <= 8'h00;
            port_a_oe <= 8'h00;
            port_b_out <= 8'h00;
            port_b_oe <= 8'h00;
            usb_data_in <= 8'h00;
            usb_module_stop_bit <= `GPU_RST_CTRL;
        end else begin
            port_a_out <= next_pa_out;
            port_a_oe <= next_pa_oe;
            port_b_out <= port_b_output_data; // RULE11
            port_b_oe <= port_b_direction; // RULE9 RULE12
            usb_data_in <= next_usb_in;
            usb_module_stop_bit <= stop;
        end
    end

    // =====================================================
    // checks
    gpio_a_dir_a: assert property (@(posedge mclk) disable iff (!rstn)
        stop && $past(stop) |-> port_a_oe == $past(port_a_direction)) // RULE1
        else $error("first-port enable does not follow direction");
    dir_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `GPU_OFS_A_DIR
        |=> s_axi_rvalid && s_axi_rdata == `GPU_UNDEF_VAL) // RULE2
        else $error("direction register read leaked its value");
    out_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
        stop && $past(stop) |-> port_a_out == $past(port_a_output_data)) // RULE3
        else $error("first-port drive differs from output data");
    pin_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `GPU_OFS_A_PIN
        |=> s_axi_rdata[7:0] == $past(port_a_pin_state)) // RULE4
        else $error("pin-state read wrong");
    pin_mix_a: assert property (@(posedge mclk) disable iff (!rstn)
        ((port_a_pin_state ^ a_sync) & ~port_a_direction) == 8'h00) // RULE5
        else $error("input bit not taken from pin");
    pin_ro_a: assert property (@(posedge mclk) disable iff (!rstn)
        do_write && aw_addr == `GPU_OFS_A_PIN
        |=> $stable(port_a_output_data) && $stable(port_a_direction)) // RULE6
        else $error("write to pin-state changed state");
    usb_own_a: assert property (@(posedge mclk) disable iff (!rstn)
        !stop ##1 !stop |-> port_a_oe == $past(usb_data_oe)) // RULE8
        else $error("usb does not own pins while running");
    port_b_a: assert property (@(posedge mclk) disable iff (!rstn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `GPU_OFS_B_DIR
        |=> s_axi_rdata == `GPU_UNDEF_VAL ##1 port_b_oe == $past(port_b_direction)) // RULE10
        else $error("second-port direction misbehaves");
    wr_cov_a: cover property (@(posedge mclk) disable iff (!rstn)
        do_write && aw_addr == `GPU_OFS_A_DIR);
    rd_cov_a: cover property (@(posedge mclk) disable iff (!rstn)
        s_axi_rvalid && s_axi_rready);
    usb_cov_a: cover property (@(posedge mclk) disable iff (!rstn)
        stop ##1 !stop);
endmodule // gpu_port

// File: shared/gpu_params.svh
`ifndef GPU_PARAMS_SVH
`define GPU_PARAMS_SVH
// register byte offsets on the AXI4-Lite slave
`define GPU_OFS_A_DIR 8'h00
`define GPU_OFS_A_OUT 8'h04
`define GPU_OFS_A_PIN 8'h08
`define GPU_OFS_B_DIR 8'h0c
`define GPU_OFS_B_OUT 8'h10
`define GPU_OFS_B_PIN 8'h14
`define GPU_OFS_CTRL 8'h18
// control register field: usb module stop
`define GPU_CTRL_STOP_BIT 0
`define GPU_RST_DIR 8'h00
`define GPU_RST_OUT 8'h00
`define GPU_RST_CTRL 1'h1
// undefined reads of write-only direction registers return this pattern
`define GPU_UNDEF_VAL 32'h0000_0000
`define GPU_RESP_OKAY 2'h0
`define GPU_RESP_SLVERR 2'h2
`endif

// File: shared/gpu_pkg.sv
package gpu_pkg;
    typedef logic [7:0] gpu_byte_t;
    typedef enum logic [2:0] {
        GPU_W_IDLE = 3'b001,
        GPU_W_RESP = 3'b010,
        GPU_W_HOLD = 3'b100
    } gpu_wstate_e;
endpackage

// File: design/gpu_sync.sv
`timescale 1ns/1ns
// =====================================================
// two-stage synchroniser for pin inputs
module gpu_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic [WIDTH-1:0] din, // asynchronous input
    output logic [WIDTH-1:0] dout // synchronised output
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_dout;

    initial begin
        if (WIDTH < 1) begin
            $error("gpu_sync: WIDTH must be at least 1");
        end
    end

    always_comb begin
        next_meta = din;
        next_dout = meta;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= next_meta;
            dout <= next_dout;
        end
    end
endmodule // gpu_sync

// File: verif/gpu_pin_model.sv
`timescale 1ns/1ns
// =====================================================
// far side of the port: pin wires with an outside driver
module gpu_pin_model (
    input wire logic [7:0] a_drv, // first-port drive value
    input wire logic [7:0] a_en, // first-port drive enables
    input wire logic [7:0] b_drv, // second-port drive value
    input wire logic [7:0] b_en, // second-port drive enables
    input wire logic [7:0] a_ext, // outside level on first port
    input wire logic [7:0] b_ext, // outside level on second port
    output logic [7:0] a_pin, // resolved first-port wires
    output logic [7:0] b_pin // resolved second-port wires
);
    // the outside device yields wherever the block drives
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            a_pin[i] = a_en[i] ? a_drv[i] : a_ext[i];
            b_pin[i] = b_en[i] ? b_drv[i] : b_ext[i];
        end
    end
endmodule // gpu_pin_model

// File: verif/tb_gpu_port.sv
`timescale 1ns/1ns
`include "gpu_params.svh"
// =====================================================
// self-checking bench for the gpio port pair
module tb_gpu_port;
    import gpu_pkg::*;
    logic mclk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, u_stop;
    logic [7:0] awaddr, araddr, a_in, a_out, a_oe, b_in, b_out, b_oe;
    logic [7:0] a_ext, b_ext, da, oa, db, ob, pa;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:8] u_out, u_oe, u_in;
    logic [33:0] note;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    int mismatches, checks_done, cycles;
    integer seed;
    gpu_port #(.WIDTH(8)) i_gpu_port (.mclk(mclk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_a_in(a_in),
        .port_a_out(a_out), .port_a_oe(a_oe), .port_b_in(b_in),
        .port_b_out(b_out), .port_b_oe(b_oe), .usb_data_out(u_out),
        .usb_data_oe(u_oe), .usb_data_in(u_in), .usb_module_stop_bit(u_stop));
    gpu_pin_model i_gpu_pin_model (.a_drv(a_out), .a_en(a_oe),
        .b_drv(b_out), .b_en(b_oe), .a_ext(a_ext), .b_ext(b_ext),
        .a_pin(a_in), .b_pin(b_in));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // =====================================================
    // comparison, verdict and bus tasks
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        bq.push_back(er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge mclk); while (awready !== 1'b1);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge mclk); while (wready !== 1'b1);
                wvalid <= 1'b0;
            end
        join
        do @(posedge mclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        rq.push_back({er, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge mclk);
    endtask
    // =====================================================
    // response watcher: oldest note against each answer
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
        if (rvalid === 1'b1 && rready === 1'b1) begin
            note = rq.pop_front();
            chk("rdata", rdata, note[31:0]);
            chk("rresp", {30'h0, rresp}, {30'h0, note[33:32]});
        end
        if (bvalid === 1'b1 && bready === 1'b1)
            chk("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
    end
    // =====================================================
    // main sequence
    initial begin
        seed = 19330;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, a_ext, b_ext, u_out, u_oe} = 48'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        rstn = 1'b0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        chk("a_oe reset", {24'h0, a_oe}, 32'h0);
        chk("stop reset", {31'h0, u_stop}, 32'h1);
        rd(`GPU_OFS_CTRL, 32'h1, `GPU_RESP_OKAY);
        rd(`GPU_OFS_A_OUT, {24'h0, `GPU_RST_OUT}, `GPU_RESP_OKAY);
        rd(`GPU_OFS_B_DIR, `GPU_UNDEF_VAL, `GPU_RESP_OKAY);
        for (int k = 0; k < 10; k++) begin
            da = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
            oa = 8'($random(seed));
            db = 8'($random(seed));
            ob = 8'($random(seed));
            a_ext <= 8'($random(seed));
            b_ext <= 8'($random(seed));
            wr(`GPU_OFS_A_DIR, {24'h0, da}, `GPU_RESP_OKAY);
            wr(`GPU_OFS_A_OUT, {24'h0, oa}, `GPU_RESP_OKAY);
            wr(`GPU_OFS_B_DIR, {24'h0, db}, `GPU_RESP_OKAY);
            wr(`GPU_OFS_B_OUT, {24'h0, ob}, `GPU_RESP_OKAY);
            repeat (4) @(posedge mclk);
            pa = (oa & da) | (a_ext & ~da);
            chk("a_oe", {24'h0, a_oe}, {24'h0, da});
            chk("a_out", {24'h0, a_out & da}, {24'h0, oa & da});
            chk("b_oe", {24'h0, b_oe}, {24'h0, db});
            chk("b_out", {24'h0, b_out & db}, {24'h0, ob & db});
            chk("usb_in", {24'h0, u_in}, {24'h0, pa});
            rd(`GPU_OFS_A_PIN, {24'h0, pa}, `GPU_RESP_OKAY);
            rd(`GPU_OFS_A_OUT, {24'h0, oa}, `GPU_RESP_OKAY);
            rd(`GPU_OFS_B_OUT, {24'h0, ob}, `GPU_RESP_OKAY);
            rd(`GPU_OFS_B_PIN, {24'h0, (ob & db) | (b_ext & ~db)},
               `GPU_RESP_OKAY);
            rd(`GPU_OFS_A_DIR, `GPU_UNDEF_VAL, `GPU_RESP_OKAY);
        end
        // a write to the pin-state place must leave data and pins alone
        wr(`GPU_OFS_A_PIN, {24'h0, ~oa}, `GPU_RESP_OKAY);
        repeat (3) @(posedge mclk);
        chk("a_out kept", {24'h0, a_out & da}, {24'h0, oa & da});
        // lane 0 strobe low: the word is answered but nothing is stored
        wstrb <= 4'he;
        wr(`GPU_OFS_A_OUT, {24'h0, ~oa}, `GPU_RESP_OKAY);
        wstrb <= 4'hf;
        rd(`GPU_OFS_A_OUT, {24'h0, oa}, `GPU_RESP_OKAY);
        wr(8'h1c, 32'h5a, `GPU_RESP_SLVERR);
        rd(8'h1c, 32'h0, `GPU_RESP_SLVERR);
        // hand the first port to the usb controller and back
        wr(`GPU_OFS_CTRL, 32'h0, `GPU_RESP_OKAY);
        u_out <= 8'($random(seed));
        u_oe <= 8'($random(seed));
        // pins reach usb_data_in through a drive flop and three more flops
        repeat (5) @(posedge mclk);
        chk("stop", {31'h0, u_stop}, 32'h0);
        chk("a_oe usb", {24'h0, a_oe}, {24'h0, u_oe});
        chk("a_out usb", {24'h0, a_out & u_oe}, {24'h0, u_out & u_oe});
        chk("usb_in usb", {24'h0, u_in},
            {24'h0, (u_out & u_oe) | (a_ext & ~u_oe)});
        rd(`GPU_OFS_CTRL, 32'h0, `GPU_RESP_OKAY);
        wr(`GPU_OFS_CTRL, 32'h1, `GPU_RESP_OKAY);
        repeat (4) @(posedge mclk);
        chk("a_oe back", {24'h0, a_oe}, {24'h0, da});
        tally_and_finish();
    end
endmodule // tb_gpu_port
